/* verilog/i2cmsc_pkg.sv */
// Shared constants, states and carriers of the two-wire serial controller
package i2cmsc_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned LINK_PERIOD_NS  = 64;
    localparam int unsigned QUARTER_STD_NS  = 2500;  // Quarter bit at 100 kHz
    localparam int unsigned QUARTER_FAST_NS = 625;   // Quarter bit at 400 kHz
    // Rounded up so the bus never runs faster than its nominal rate
    localparam logic [5:0]  QUARTER_STD_CYC  =
        6'((QUARTER_STD_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
    localparam logic [5:0]  QUARTER_FAST_CYC =
        6'((QUARTER_FAST_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);

    // ------------------------------------------------------------------
    // Bit slot phases and byte layout
    // ------------------------------------------------------------------
    localparam logic [1:0]  PH_LOW0   = 2'h0;
    localparam logic [1:0]  PH_LOW1   = 2'h1;
    localparam logic [1:0]  PH_HIGH0  = 2'h2;
    localparam logic [1:0]  PH_HIGH1  = 2'h3;
    localparam logic [3:0]  BYTE_BITS = 4'h8;
    localparam int unsigned DIR_BIT   = 0;
    localparam int unsigned MSB_BIT   = 7;
    localparam logic [6:0]  GC_ADDR   = 7'h00;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       enable;
        logic       ack_en;
        logic       gc_en;
        logic       fast;
        logic [6:0] own_addr;
    } i2cmsc_cfg_s;

    typedef struct packed {
        logic bus_busy;
        logic master;
        logic transmitter;
        logic addressed;
        logic general_call;
        logic ack_received;
        logic arb_lost;
    } i2cmsc_status_s;

    typedef enum logic [2:0] {
        ST_IDLE, ST_START, ST_DATA, ST_HOLD, ST_STOP, ST_IGNORE
    } i2cmsc_state_e;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam i2cmsc_cfg_s    CFG_RST    = '0;
    localparam i2cmsc_status_s STATUS_RST = '0;
    localparam logic [7:0]     BYTE_RST   = 8'h00;
    localparam logic [1:0]     PIN_IDLE   = 2'h3;

endpackage

/* verilog/i2cmsc_top.sv */
// Two-wire serial controller: master and slave byte engine on the link clock
module i2cmsc_top
    import i2cmsc_pkg::*;
(
    // Core clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    // Link clock
    input  wire logic        link_clk_i,
    // Configuration levels
    input  wire logic        module_enable_i,
    input  wire logic        ack_assert_enable_i,
    input  wire logic        general_call_enable_i,
    input  wire logic        fast_mode_i,
    input  wire logic [6:0]  own_address_register_i,
    // Command pulses and byte to send
    input  wire logic        start_request_i,
    input  wire logic        stop_request_i,
    input  wire logic        byte_go_i,
    input  wire logic [7:0]  tx_data_i,
    // Results
    output logic [7:0]       rx_data_o,
    output logic             byte_event_o,
    output i2cmsc_status_s   status_o,
    // Bus pins, open drain
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe_o,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_o
);

    localparam int unsigned C2L_W = $bits(i2cmsc_cfg_s) + 3;
    localparam int unsigned L2C_W = $bits(i2cmsc_status_s) + 1;

    // ------------------------------------------------------------------
    // Core domain: configuration, command toggles, byte latch
    // ------------------------------------------------------------------
    i2cmsc_cfg_s           cfg_d;
    i2cmsc_cfg_s           cfg_q;
    logic [7:0]            tx_q;
    logic                  start_tgl_q;
    logic                  stop_tgl_q;
    logic                  go_tgl_q;
    wire logic             cmd_ok    = cfg_q.enable;
    wire logic             start_acc = cmd_ok & start_request_i;
    wire logic             stop_acc  = cmd_ok & stop_request_i;
    wire logic             go_acc    = cmd_ok & byte_go_i;

    assign cfg_d = {module_enable_i, ack_assert_enable_i, general_call_enable_i,
                    fast_mode_i, own_address_register_i};

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            cfg_q       <= CFG_RST;
            tx_q        <= BYTE_RST;
            start_tgl_q <= 1'b0;
            stop_tgl_q  <= 1'b0;
            go_tgl_q    <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            // Byte held stable until the next accepted start or go request
            if (start_acc || go_acc) begin
                tx_q <= tx_data_i;
            end
            start_tgl_q <= start_tgl_q ^ start_acc;
            stop_tgl_q  <= stop_tgl_q ^ stop_acc;
            go_tgl_q    <= go_tgl_q ^ go_acc;
        end
    end

    // ------------------------------------------------------------------
    // Crossing into the link domain
    // ------------------------------------------------------------------
    // Config bits are quasi-static levels; toggles mark commands
    logic [C2L_W-1:0]      c2l_s1_q;
    logic [C2L_W-1:0]      c2l_s2_q;
    logic [2:0]            tgl_prev_q;

    always_ff @(posedge link_clk_i) begin
        c2l_s1_q   <= {cfg_q, start_tgl_q, stop_tgl_q, go_tgl_q};
        c2l_s2_q   <= c2l_s1_q;
        tgl_prev_q <= c2l_s2_q[2:0];
    end

    i2cmsc_cfg_s           lcfg;
    assign lcfg = c2l_s2_q[C2L_W-1:3];

    wire logic [2:0]       cmd_edge  = c2l_s2_q[2:0] ^ tgl_prev_q;
    wire logic             start_cmd = cmd_edge[2];
    wire logic             stop_cmd  = cmd_edge[1];
    wire logic             go_cmd    = cmd_edge[0];
    // Disable holds the whole link engine in reset
    wire logic             l_en      = lcfg.enable;

    // ------------------------------------------------------------------
    // Pin synchroniser and bus condition detect
    // ------------------------------------------------------------------
    logic [1:0]            pin_s1_q;
    logic [1:0]            pin_s2_q;
    logic [1:0]            pin_s3_q;

    always_ff @(posedge link_clk_i) begin
        if (!l_en) begin
            pin_s1_q <= PIN_IDLE;
            pin_s2_q <= PIN_IDLE;
            pin_s3_q <= PIN_IDLE;
        end else begin
            pin_s1_q <= {scl_i, sda_i};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    wire logic             scl_s     = pin_s2_q[1];
    wire logic             sda_s     = pin_s2_q[0];
    wire logic             scl_p     = pin_s3_q[1];
    wire logic             sda_p     = pin_s3_q[0];
    wire logic             start_det = scl_s & scl_p & sda_p & ~sda_s;
    wire logic             stop_det  = scl_s & scl_p & ~sda_p & sda_s;
    wire logic             scl_rise  = scl_s & ~scl_p;
    wire logic             scl_fall  = ~scl_s & scl_p;

    // ------------------------------------------------------------------
    // Engine state
    // ------------------------------------------------------------------
    i2cmsc_state_e         state_q;
    logic [1:0]            phase_q;
    logic [5:0]            qcnt_q;
    logic [3:0]            bit_cnt_q;
    logic                  ack_slot_q;
    logic [7:0]            sh_q;
    logic [7:0]            rx_q;
    logic                  out_q;
    logic                  ack_drive_q;
    logic                  tx_role_q;
    logic                  master_q;
    logic                  addr_phase_q;
    logic                  addressed_q;
    logic                  gc_q;
    logic                  ack_rx_q;
    logic                  arb_lost_q;
    logic                  bus_busy_q;
    logic                  done_tgl_q;
    logic                  start_pend_q;
    logic                  stop_pend_q;
    logic                  go_pend_q;
    logic                  scl_oe_q;
    logic                  sda_oe_q;

    // ------------------------------------------------------------------
    // Master bit timing
    // ------------------------------------------------------------------
    wire logic             in_data   = (state_q == ST_DATA);
    wire logic             in_start  = (state_q == ST_START);
    wire logic             in_stop   = (state_q == ST_STOP);
    wire logic             tim_run   = master_q & (in_data | in_start | in_stop);
    wire logic [5:0]       qlen      = lcfg.fast ? QUARTER_FAST_CYC
                                                 : QUARTER_STD_CYC;
    // Another device holding the clock low stretches our high phase
    wire logic             stall     = (phase_q == PH_HIGH0) & ~scl_s & ~in_start;
    wire logic             tick      = tim_run & ~stall & (qcnt_q == qlen - 6'h01);
    wire logic             last_q    = tick & (phase_q == PH_HIGH1);
    wire logic             m_sample  = tick & (phase_q == PH_HIGH0) & in_data;
    wire logic             m_drive   = last_q & in_data;
    wire logic             sample_ev = master_q ? m_sample : scl_rise;
    wire logic             drive_ev  = master_q ? m_drive : (~master_q & scl_fall);

    // ------------------------------------------------------------------
    // Address compare and acknowledge decision
    // ------------------------------------------------------------------
    wire logic             addr_hit  = (sh_q[7:1] == lcfg.own_addr);
    wire logic             gc_hit    = lcfg.gc_en & (sh_q[7:1] == GC_ADDR);
    wire logic             data_full = (bit_cnt_q == BYTE_BITS);
    wire logic             slave_adr = addr_phase_q & ~master_q;
    wire logic             lost_bit  = master_q & tx_role_q & out_q & ~sda_s;
    wire logic             slave_nak = ~master_q & tx_role_q & ~ack_rx_q & ~addr_phase_q;

    // ------------------------------------------------------------------
    // Byte engine
    // ------------------------------------------------------------------
    always_ff @(posedge link_clk_i) begin
        if (!l_en) begin
            state_q      <= ST_IDLE;
            phase_q      <= PH_LOW0;
            qcnt_q       <= 6'h00;
            bit_cnt_q    <= 4'h0;
            ack_slot_q   <= 1'b0;
            sh_q         <= BYTE_RST;
            rx_q         <= BYTE_RST;
            out_q        <= 1'b1;
            ack_drive_q  <= 1'b0;
            tx_role_q    <= 1'b0;
            master_q     <= 1'b0;
            addr_phase_q <= 1'b0;
            addressed_q  <= 1'b0;
            gc_q         <= 1'b0;
            ack_rx_q     <= 1'b0;
            arb_lost_q   <= 1'b0;
            bus_busy_q   <= 1'b0;
            done_tgl_q   <= 1'b0;
            start_pend_q <= 1'b0;
            stop_pend_q  <= 1'b0;
            go_pend_q    <= 1'b0;
        end else begin
            if (start_det) begin
                bus_busy_q <= 1'b1;
            end else if (stop_det) begin
                bus_busy_q <= 1'b0;
            end
            if (!tim_run || tick) begin
                qcnt_q <= 6'h00;
            end else if (!stall) begin
                qcnt_q <= qcnt_q + 6'h01;
            end
            if (!tim_run) begin
                phase_q <= PH_LOW0;
            end else if (tick) begin
                phase_q <= phase_q + 2'h1;
            end

            unique case (state_q)
                ST_IDLE: begin
                    if (start_pend_q && !bus_busy_q) begin
                        state_q      <= ST_START;
                        master_q     <= 1'b1;
                        start_pend_q <= 1'b0;
                        sh_q         <= tx_q;
                        tx_role_q    <= 1'b1;
                        addr_phase_q <= 1'b1;
                        arb_lost_q   <= 1'b0;
                    end
                end
                ST_START: begin
                    if (last_q) begin
                        state_q    <= ST_DATA;
                        bit_cnt_q  <= 4'h0;
                        ack_slot_q <= 1'b0;
                        out_q      <= sh_q[MSB_BIT];
                    end
                end
                ST_DATA: begin
                    if (sample_ev && !ack_slot_q) begin
                        sh_q      <= {sh_q[6:0], sda_s};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                        if (lost_bit) begin
                            arb_lost_q <= 1'b1;
                            master_q   <= 1'b0;
                            state_q    <= ST_IGNORE;
                            done_tgl_q <= ~done_tgl_q;
                        end
                    end else if (sample_ev) begin
                        ack_rx_q <= ~sda_s;
                    end
                    if (drive_ev && !ack_slot_q && !data_full) begin
                        out_q <= sh_q[MSB_BIT];
                    end else if (drive_ev && !ack_slot_q) begin
                        ack_slot_q <= 1'b1;
                        if (slave_adr && (addr_hit || gc_hit)) begin
                            ack_drive_q <= 1'b1;
                            addressed_q <= 1'b1;
                            gc_q        <= gc_hit & ~addr_hit;
                        end else if (slave_adr) begin
                            state_q <= ST_IGNORE;
                        end else begin
                            ack_drive_q <= ~tx_role_q & lcfg.ack_en;
                        end
                    end else if (drive_ev) begin
                        ack_slot_q  <= 1'b0;
                        ack_drive_q <= 1'b0;
                        bit_cnt_q   <= 4'h0;
                        rx_q        <= sh_q;
                        done_tgl_q  <= ~done_tgl_q;
                        if (addr_phase_q) begin
                            addr_phase_q <= 1'b0;
                            // Write sends from master, read sends from slave
                            tx_role_q <= master_q ^ sh_q[DIR_BIT];
                        end
                        // Nacked slave transmitter lets the master finish
                        state_q <= slave_nak ? ST_IGNORE : ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (master_q && (stop_pend_q || stop_cmd)) begin
                        state_q     <= ST_STOP;
                        stop_pend_q <= 1'b0;
                    end else if (go_pend_q) begin
                        state_q   <= ST_DATA;
                        go_pend_q <= 1'b0;
                        sh_q      <= tx_q;
                        out_q     <= tx_q[MSB_BIT];
                    end
                end
                ST_STOP: begin
                    if (last_q) begin
                        state_q  <= ST_IDLE;
                        master_q <= 1'b0;
                    end
                end
                ST_IGNORE: begin
                end
            endcase

            if (!master_q && stop_det) begin
                state_q     <= ST_IDLE;
                addressed_q <= 1'b0;
                ack_drive_q <= 1'b0;
            end else if (!master_q && start_det) begin
                state_q      <= ST_DATA;
                bit_cnt_q    <= 4'h0;
                ack_slot_q   <= 1'b0;
                ack_drive_q  <= 1'b0;
                tx_role_q    <= 1'b0;
                addr_phase_q <= 1'b1;
                addressed_q  <= 1'b0;
                gc_q         <= 1'b0;
            end

            // Commands set after any clear so none is lost
            if (!master_q && state_q != ST_HOLD) begin
                stop_pend_q <= 1'b0;
            end
            if (start_cmd) begin
                start_pend_q <= 1'b1;
            end
            if (stop_cmd) begin
                stop_pend_q <= 1'b1;
            end
            if (go_cmd) begin
                go_pend_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------
    wire logic             scl_lo_d  = (in_data & master_q & ~phase_q[1])
                                     | (in_start & (phase_q == PH_HIGH1))
                                     | (in_stop & ~phase_q[1])
                                     | (state_q == ST_HOLD);
    wire logic             sda_lo_d  = (in_start & phase_q[1])
                                     | (in_stop & (phase_q != PH_HIGH1))
                                     | (in_data & ~ack_slot_q & tx_role_q & ~out_q)
                                     | (in_data & ack_slot_q & ack_drive_q);

    always_ff @(posedge link_clk_i) begin
        if (!l_en) begin
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else begin
            scl_oe_q <= scl_lo_d;
            sda_oe_q <= sda_lo_d;
        end
    end

    assign scl_oe_o = scl_oe_q;
    assign sda_oe_o = sda_oe_q;

    // ------------------------------------------------------------------
    // Crossing back to the core domain
    // ------------------------------------------------------------------
    i2cmsc_status_s        status_l;
    assign status_l = {bus_busy_q, master_q, tx_role_q, addressed_q, gc_q,
                       ack_rx_q, arb_lost_q};

    logic [L2C_W-1:0]      l2c_s1_q;
    logic [L2C_W-1:0]      l2c_s2_q;
    logic                  done_prev_q;
    logic [7:0]            rx_data_q;
    logic                  byte_event_q;
    i2cmsc_status_s        status_q;
    logic                  scl_o_q;
    logic                  sda_o_q;
    wire logic             done_edge = l2c_s2_q[0] ^ done_prev_q;

    always_ff @(posedge clk_i) begin
        done_prev_q <= l2c_s2_q[0];
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            l2c_s1_q     <= '0;
            l2c_s2_q     <= '0;
            rx_data_q    <= BYTE_RST;
            byte_event_q <= 1'b0;
            status_q     <= STATUS_RST;
            scl_o_q      <= 1'b0;
            sda_o_q      <= 1'b0;
        end else begin
            l2c_s1_q     <= {status_l, done_tgl_q};
            l2c_s2_q     <= l2c_s1_q;
            // Link byte register is quiet for a full bit time after the toggle
            if (done_edge) begin
                rx_data_q <= rx_q;
            end
            byte_event_q <= done_edge;
            status_q     <= l2c_s2_q[L2C_W-1:1];
            scl_o_q      <= 1'b0;
            sda_o_q      <= 1'b0;
        end
    end

    assign rx_data_o    = rx_data_q;
    assign byte_event_o = byte_event_q;
    assign status_o     = status_q;
    assign scl_o        = scl_o_q;
    assign sda_o        = sda_o_q;

endmodule

/* bench/i2cmsc_assertions.sv */
// Port-level checks of the two-wire controller
module i2cmsc_assertions
    import i2cmsc_pkg::*;
(
    // Clocks, reset and levels
    input wire logic           clk_i,
    input wire logic           reset_n_i,
    input wire logic           link_clk_i,
    input wire logic           module_enable_i,
    input wire logic           general_call_enable_i,
    // Results and pins
    input wire logic [7:0]     rx_data_o,
    input wire logic           byte_event_o,
    input wire i2cmsc_status_s status_o,
    input wire logic           scl_o,
    input wire logic           scl_oe_o,
    input wire logic           sda_o,
    input wire logic           sda_oe_o
);
    a_event_one_cycle: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        byte_event_o |=> !byte_event_o) else $error("byte event too long");
    a_rx_with_event: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        $changed(rx_data_o) |-> byte_event_o) else $error("byte moved without event");
    a_pins_pull_low: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        scl_o == 1'b0 && sda_o == 1'b0) else $error("pin driven high");
    a_gc_needs_enable: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        status_o.general_call |-> general_call_enable_i) else $error("general call while off");
    a_one_role: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        status_o.master |-> !status_o.addressed) else $error("master and slave at once");
    a_arb_withdraws: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        status_o.arb_lost |-> !status_o.master) else $error("kept master after loss");
    a_idle_released: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        $fell(status_o.bus_busy) |-> !scl_oe_o && !sda_oe_o) else $error("drives idle bus");
    a_off_quiet: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
        !module_enable_i [*8] |-> !scl_oe_o && !sda_oe_o) else $error("drives while off");
endmodule

/* bench/i2cmsc_partner.sv */
// Behavioural slave on the far side of the two-wire bus
module i2cmsc_partner #(
    parameter logic [6:0] ADDR  = 7'h50,
    parameter logic [7:0] RDATA = 8'h5a
) (
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      sda_oe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sh    = 8'h00;
    logic       first = 1'b1;
    logic       sel   = 1'b0;
    logic       rd    = 1'b0;
    int         n     = 0;
    initial sda_oe_o = 1'b0;
    // Start or stop: both restart the frame and free the line
    always @(sda_i) begin
        // Data may move in the same step as the clock falls; let it settle
        #1;
        if (scl_i === 1'b1) begin
            n = 0;
            first = 1'b1;
            rd = 1'b0;
            sda_oe_o = 1'b0;
        end
    end
    always @(posedge scl_i) begin
        if (n < 8) begin
            sh = {sh[6:0], sda_i};
            n++;
        end else if (rd && sda_i) begin
            rd = 1'b0;
        end
    end
    always @(negedge scl_i) begin
        if (n == 8) begin
            sda_oe_o = !rd && (first ? sh[7:1] == ADDR : sel);
            n = 9;
        end else begin
            if (n == 9) begin
                sel = first ? sh[7:1] == ADDR : sel;
                rd = rd || (first && sel && sh[0]);
                first = 1'b0;
                n = 0;
            end
            sda_oe_o = rd && n < 8 && !RDATA[3'(7 - n)];
        end
    end
endmodule

/* bench/i2cmsc_tb.sv */
// Bench: controller as master against a behavioural slave
module i2cmsc_tb import i2cmsc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic           clk_i      = 1'b0;
    logic           link_clk_i = 1'b0;
    logic           reset_n_i  = 1'b0;
    logic           en         = 1'b0;
    logic           ack_en     = 1'b1;
    logic           st         = 1'b0;
    logic           sp         = 1'b0;
    logic           go         = 1'b0;
    logic [7:0]     tx         = 8'h00;
    logic [7:0]     rx;
    logic           ev;
    logic           scl_oe;
    logic           sda_oe;
    logic           p_oe;
    i2cmsc_status_s sts;
    wire logic      scl = !scl_oe;
    wire logic      sda = !(sda_oe || p_oe);
    int             n_mismatch = 0;
    int             cmp_count  = 0;
    always #5 clk_i = !clk_i;
    initial begin
        #3;
        forever #32 link_clk_i = !link_clk_i;
    end
    i2cmsc_top dut_u (
        .clk_i, .reset_n_i, .link_clk_i, .module_enable_i(en), .ack_assert_enable_i(ack_en),
        .general_call_enable_i(1'b0), .fast_mode_i(1'b1), .own_address_register_i(7'h11),
        .start_request_i(st), .stop_request_i(sp), .byte_go_i(go), .tx_data_i(tx),
        .rx_data_o(rx), .byte_event_o(ev), .status_o(sts), .scl_i(scl), .scl_o(),
        .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe)
    );
    i2cmsc_partner slave_u (.scl_i(scl), .sda_i(sda), .sda_oe_o(p_oe));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // One byte slot; status needs a few cycles to cross over
    task automatic byte_op(input logic is_start, input logic [7:0] d);
        int i;
        tx <= d;
        st <= is_start;
        go <= !is_start;
        @(posedge clk_i);
        st <= 1'b0;
        go <= 1'b0;
        for (i = 0; i < 6000 && ev !== 1'b1; i++) @(posedge clk_i);
        if (ev !== 1'b1) begin
            n_mismatch++;
            tally_and_finish();
        end
        repeat (4) @(posedge clk_i);
    endtask
    task automatic stop_op();
        int i;
        sp <= 1'b1;
        @(posedge clk_i);
        sp <= 1'b0;
        // Master status drops a little after the bus goes free
        for (i = 0; i < 3000 && (sts.bus_busy !== 1'b0 || sts.master !== 1'b0); i++)
            @(posedge clk_i);
        check("busy", 8'(sts.bus_busy), 8'h00);
        check("master", 8'(sts.master), 8'h00);
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        reset_n_i <= 1'b1;
        en <= 1'b1;
        repeat (40) @(posedge clk_i);
        byte_op(1'b1, 8'ha0);
        check("addr", rx, 8'ha0);
        check("ack", 8'(sts.ack_received), 8'h01);
        check("role", 8'({sts.master, sts.transmitter}), 8'h03);
        byte_op(1'b0, 8'h3c);
        check("data", rx, 8'h3c);
        check("ack", 8'(sts.ack_received), 8'h01);
        stop_op();
        byte_op(1'b1, 8'ha2);
        check("nack", 8'(sts.ack_received), 8'h00);
        stop_op();
        ack_en <= 1'b0;
        byte_op(1'b1, 8'ha1);
        check("rd ack", 8'(sts.ack_received), 8'h01);
        byte_op(1'b0, 8'h00);
        check("rd data", rx, 8'h5a);
        check("role", 8'({sts.master, sts.transmitter}), 8'h02);
        stop_op();
        tally_and_finish();
    end
endmodule
bind i2cmsc_top i2cmsc_assertions chk_u (
    .clk_i, .reset_n_i, .link_clk_i, .module_enable_i, .general_call_enable_i, .rx_data_o,
    .byte_event_o, .status_o, .scl_o, .scl_oe_o, .sda_o, .sda_oe_o
);
